// ==== design/pmrm_pkg.sv ====
// pmrm_pkg: constants, state encoding and state record of the main
// register page of the power-management device.
// assumes one core clock; serial bus pins arrive unsynchronised.
package pmrm_pkg;

    localparam int NCTL = 45;

    localparam logic [6:0] TARGET_ADDR_RST = 7'h5E;
    localparam logic [4:0] TEN_BIT_PREFIX  = 5'h1E;

    localparam logic [7:0] OFF_ID_LOW      = 8'h00;
    localparam logic [7:0] OFF_ID_HIGH     = 8'h01;
    localparam logic [7:0] OFF_IRQ_STATUS  = 8'h02;
    localparam logic [7:0] OFF_IRQ_MASKS   = 8'h03;
    localparam logic [7:0] OFF_TEMP_IND    = 8'h04;
    localparam logic [7:0] OFF_SHUT_CAUSE  = 8'h05;
    localparam logic [7:0] OFF_SD3_SLEEP   = 8'h24;
    localparam logic [7:0] OFF_DISCH_A     = 8'h40;
    localparam logic [7:0] OFF_DISCH_B     = 8'h41;
    localparam logic [7:0] OFF_DISCH_C     = 8'h42;
    localparam logic [7:0] OFF_SYS_GOOD3   = 8'h43;
    localparam logic [7:0] OFF_SD_DIS_MODE = 8'h9C;
    localparam logic [7:0] OFF_RAIL_EN_A   = 8'hA0;
    localparam logic [7:0] OFF_RAIL_EN_B   = 8'hA1;
    localparam logic [7:0] OFF_FMASK_A     = 8'hA2;
    localparam logic [7:0] OFF_FMASK_B     = 8'hA3;
    localparam logic [7:0] OFF_TREE_CTL    = 8'hAC;
    localparam logic [7:0] OFF_TERM_DISCH  = 8'hAD;
    localparam logic [7:0] OFF_LIN1_SW2    = 8'hAE;
    localparam logic [7:0] OFF_GOOD_A      = 8'hB0;
    localparam logic [7:0] OFF_GOOD_B      = 8'hB1;
    localparam logic [7:0] OFF_FAULT_A     = 8'hB2;
    localparam logic [7:0] OFF_FAULT_B     = 8'hB3;
    localparam logic [7:0] OFF_TEMP_CRIT   = 8'hB4;
    localparam logic [7:0] OFF_TEMP_HOT    = 8'hB5;

    // offsets of the stored, otp-loaded registers, index order
    localparam logic [7:0] CTL_OFFS [NCTL] = '{
        OFF_ID_LOW, OFF_ID_HIGH,
        8'h20, 8'h21, 8'h22, 8'h23, OFF_SD3_SLEEP,
        8'h25, 8'h26, 8'h27, 8'h28, 8'h29,
        OFF_DISCH_A, OFF_DISCH_B, OFF_DISCH_C, OFF_SYS_GOOD3,
        8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97,
        8'h98, 8'h99, 8'h9A, 8'h9B, OFF_SD_DIS_MODE, 8'h9D, 8'h9F,
        OFF_RAIL_EN_A, OFF_RAIL_EN_B, OFF_FMASK_A, OFF_FMASK_B,
        8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'hA9, 8'hAA, 8'hAB,
        OFF_TREE_CTL, OFF_TERM_DISCH, OFF_LIN1_SW2
    };
    localparam int ID_LAST_IDX = 1;

    localparam logic [7:0] IRQ_BITS       = 8'h89;
    localparam int         IRQ_FAULT_BIT  = 7;
    localparam int         IRQ_SHUT_BIT   = 3;
    localparam int         IRQ_HOT_BIT    = 0;
    localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
    localparam logic [7:0] IRQ_MASKS_RST  = 8'hFF;
    localparam logic [7:0] CAUSE_RST      = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

    typedef enum logic [7:0] {
        PMRM_IDLE    = 8'b0000_0001,
        PMRM_ADDR    = 8'b0000_0010,
        PMRM_ADDR_AK = 8'b0000_0100,
        PMRM_RX      = 8'b0000_1000,
        PMRM_RX_AK   = 8'b0001_0000,
        PMRM_TX      = 8'b0010_0000,
        PMRM_TX_AK   = 8'b0100_0000,
        PMRM_SPARE   = 8'b1000_0000
    } pmrm_state_t;

    typedef struct packed {
        pmrm_state_t                state;
        logic                       scl_s1;
        logic                       scl_s2;
        logic                       scl_s3;
        logic                       sda_s1;
        logic                       sda_s2;
        logic                       sda_s3;
        logic                       sda_oe;
        logic                       sda_out;
        logic [3:0]                 bit_cnt;
        logic [7:0]                 shifter;
        logic                       rw;
        logic [7:0]                 ptr;
        logic                       ptr_done;
        logic [6:0]                 target;
        logic [7:0]                 irq_status;
        logic [7:0]                 irq_masks;
        logic [7:0]                 cause;
        logic [NCTL-1:0][7:0]       ctl;
    } pmrm_regs_t;

endpackage : pmrm_pkg

// ==== design/pmrm_top.sv ====
// pmrm_top: serial-bus target and main register page of the
// power-management device.
// assumes scl/sda come from the pins unsynchronised; status and event
// inputs and the otp image come from logic on core_clk.

// Behaviour
// - page answers at 7-bit target address 0x5E after reset.
// - page is readable and writable without programming mode.
// - identity registers 00h and 01h accept writes only in programming mode.
// - target address reloadable through a dedicated address configuration port.
// - registers with undefined reset load from the otp image.
// - shutdown cause bits live at offset 05h.
// - stepdown disable and pulse-skip mode selection at offset 9Ch.
// - system good delay for general output three at offset 43h.
// - per-rail enable bits at offset A0h.
// - more rail enables and general output drive at offset A1h.
// - fault mask bits at offsets A2h and A3h.
// - power-good status read at offsets B0h and B1h.
// - power-fault status read at offsets B2h and B3h.
// - good tree control input combining at offset ACh.
// - discharge controls at offsets 40h to 42h.
// - stepdown three sleep voltage at offset 24h.
// - termination regulator discharge setting at offset ADh.
// - linear one and switch two control at offset AEh.
// - only 7-bit addresses decode; ten-bit and general call ignored.
// - interrupt flag cleared by writing one, except shutdown flag while cause nonzero; zero leaves it.
module pmrm_top (
    input  wire logic                             core_clk,
    input  wire logic                             rst,
    input  wire logic                             scl_in,
    input  wire logic                             sda_in,
    output logic                                  sda_out,
    output logic                                  sda_oe,
    input  wire logic                             prog_mode,
    input  wire logic [6:0]                       target_addr_value,
    input  wire logic                             target_addr_write,
    input  wire logic                             otp_load,
    input  wire logic [pmrm_pkg::NCTL-1:0][7:0]   otp_image,
    input  wire logic                             fault_event,
    input  wire logic                             shutdown_event,
    input  wire logic                             hot_event,
    input  wire logic [7:0]                       cause_set,
    input  wire logic                             die_hot,
    input  wire logic [15:0]                      good_status,
    input  wire logic [15:0]                      fault_status,
    input  wire logic [7:0]                       temp_crit_status,
    input  wire logic [7:0]                       temp_hot_status,
    output logic [pmrm_pkg::NCTL-1:0][7:0]        ctl_image,
    output logic [7:0]                            interrupt_status,
    output logic [7:0]                            interrupt_masks,
    output logic [7:0]                            shutdown_cause,
    output logic [6:0]                            target_addr
);
    import pmrm_pkg::*;

    localparam pmrm_regs_t RESET_STATE = '{
        state:      PMRM_IDLE,
        scl_s1:     1'b1,
        scl_s2:     1'b1,
        scl_s3:     1'b1,
        sda_s1:     1'b1,
        sda_s2:     1'b1,
        sda_s3:     1'b1,
        sda_oe:     1'b0,
        sda_out:    1'b0,
        bit_cnt:    4'h0,
        shifter:    8'h00,
        rw:         1'b0,
        ptr:        8'h00,
        ptr_done:   1'b0,
        target:     TARGET_ADDR_RST,
        irq_status: IRQ_STATUS_RST,
        irq_masks:  IRQ_MASKS_RST,
        cause:      CAUSE_RST,
        ctl:        '0
    };

    pmrm_regs_t q;
    pmrm_regs_t d;

    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       addr_match;
    logic       wr_en;
    logic [7:0] wr_off;
    logic [7:0] wr_data;
    logic [7:0] load_byte;
    logic       ctl_hit;
    logic [5:0] ctl_idx;
    logic       rd_hit;
    logic [5:0] rd_idx;

    // search of the stored register table
    function automatic logic [6:0] find_ctl(input logic [7:0] off);
        logic [6:0] res;
        res = 7'h00;
        for (int i = 0; i < NCTL; i++) begin
            if (CTL_OFFS[i] == off) begin
                res = {1'b1, 6'(i)};
            end
        end
        return res;
    endfunction : find_ctl

    assign {ctl_hit, ctl_idx} = find_ctl(wr_off);
    assign {rd_hit, rd_idx}   = find_ctl(q.ptr);

    // read multiplexer
    always_comb begin
        load_byte = 8'h00;
        if (rd_hit) begin
            load_byte = q.ctl[rd_idx];
        end else begin
            case (q.ptr)
                OFF_IRQ_STATUS: load_byte = q.irq_status & IRQ_BITS;
                OFF_IRQ_MASKS:  load_byte = q.irq_masks;
                OFF_TEMP_IND:   load_byte = {7'h00, die_hot};
                OFF_SHUT_CAUSE: load_byte = q.cause;
                OFF_GOOD_A:     load_byte = good_status[7:0];
                OFF_GOOD_B:     load_byte = good_status[15:8];
                OFF_FAULT_A:    load_byte = fault_status[7:0];
                OFF_FAULT_B:    load_byte = fault_status[15:8];
                OFF_TEMP_CRIT:  load_byte = temp_crit_status;
                OFF_TEMP_HOT:   load_byte = temp_hot_status;
                default:        load_byte = 8'h00;
            endcase
        end
    end

    // bus conditions from the synchronised pins
    assign scl_rise  = q.scl_s2 & ~q.scl_s3;
    assign scl_fall  = ~q.scl_s2 & q.scl_s3;
    assign bus_start = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
    assign bus_stop  = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;
    assign addr_match = (q.shifter[7:1] == q.target)
                      && (q.shifter[7:1] != 7'h00)
                      && (q.shifter[7:3] != TEN_BIT_PREFIX);

    always_comb begin
        d = q;
        wr_en   = 1'b0;
        wr_off  = 8'h00;
        wr_data = 8'h00;

        d.scl_s1 = scl_in;
        d.scl_s2 = q.scl_s1;
        d.scl_s3 = q.scl_s2;
        d.sda_s1 = sda_in;
        d.sda_s2 = q.sda_s1;
        d.sda_s3 = q.sda_s2;
        d.sda_out = 1'b0;

        // byte engine; sda changes only while scl is low
        case (q.state)
            PMRM_IDLE: begin
                d.sda_oe = 1'b0;
            end
            PMRM_ADDR: begin
                if (scl_rise) begin
                    d.shifter = {q.shifter[6:0], q.sda_s2};
                    d.bit_cnt = q.bit_cnt + 4'h1;
                end
                if (scl_fall && q.bit_cnt == BITS_PER_BYTE) begin
                    if (addr_match) begin
                        d.sda_oe = 1'b1;
                        d.rw     = q.shifter[0];
                        d.state  = PMRM_ADDR_AK;
                    end else begin
                        d.state  = PMRM_IDLE;
                    end
                end
            end
            PMRM_ADDR_AK: begin
                if (scl_fall) begin
                    d.bit_cnt = 4'h0;
                    if (q.rw) begin
                        d.shifter = load_byte;
                        d.sda_oe  = ~load_byte[7];
                        d.state   = PMRM_TX;
                    end else begin
                        d.sda_oe  = 1'b0;
                        d.state   = PMRM_RX;
                    end
                end
            end
            PMRM_RX: begin
                if (scl_rise) begin
                    d.shifter = {q.shifter[6:0], q.sda_s2};
                    d.bit_cnt = q.bit_cnt + 4'h1;
                end
                if (scl_fall && q.bit_cnt == BITS_PER_BYTE) begin
                    d.sda_oe = 1'b1;
                    d.state  = PMRM_RX_AK;
                    if (!q.ptr_done) begin
                        d.ptr      = q.shifter;
                        d.ptr_done = 1'b1;
                    end else begin
                        wr_en   = 1'b1;
                        wr_off  = q.ptr;
                        wr_data = q.shifter;
                        d.ptr   = q.ptr + 8'h01;
                    end
                end
            end
            PMRM_RX_AK: begin
                if (scl_fall) begin
                    d.sda_oe  = 1'b0;
                    d.bit_cnt = 4'h0;
                    d.state   = PMRM_RX;
                end
            end
            PMRM_TX: begin
                if (scl_rise) begin
                    d.bit_cnt = q.bit_cnt + 4'h1;
                end
                if (scl_fall) begin
                    if (q.bit_cnt == BITS_PER_BYTE) begin
                        d.sda_oe = 1'b0;
                        d.ptr    = q.ptr + 8'h01;
                        d.state  = PMRM_TX_AK;
                    end else begin
                        d.shifter = {q.shifter[6:0], 1'b0};
                        d.sda_oe  = ~q.shifter[6];
                    end
                end
            end
            PMRM_TX_AK: begin
                if (scl_rise && q.sda_s2) begin
                    d.state = PMRM_IDLE;
                end else if (scl_fall) begin
                    d.bit_cnt = 4'h0;
                    d.shifter = load_byte;
                    d.sda_oe  = ~load_byte[7];
                    d.state   = PMRM_TX;
                end
            end
            default: begin
                d.sda_oe = 1'b0;
                d.state  = PMRM_IDLE;
            end
        endcase

        if (bus_start) begin
            d.state    = PMRM_ADDR;
            d.bit_cnt  = 4'h0;
            d.sda_oe   = 1'b0;
            d.ptr_done = 1'b0;
        end else if (bus_stop) begin
            d.state  = PMRM_IDLE;
            d.sda_oe = 1'b0;
        end

        // register writes
        if (wr_en) begin
            if (ctl_hit) begin
                if (ctl_idx > 6'(ID_LAST_IDX) || prog_mode) begin
                    d.ctl[ctl_idx] = wr_data;
                end
            end else begin
                case (wr_off)
                    OFF_IRQ_STATUS: begin
                        d.irq_status = q.irq_status
                                     & ~(wr_data & IRQ_BITS);
                        if (q.cause != 8'h00) begin
                            d.irq_status[IRQ_SHUT_BIT] =
                                q.irq_status[IRQ_SHUT_BIT];
                        end
                    end
                    OFF_IRQ_MASKS: begin
                        d.irq_masks = (q.irq_masks & ~IRQ_BITS)
                                    | (wr_data & IRQ_BITS);
                    end
                    OFF_SHUT_CAUSE: begin
                        d.cause = q.cause & ~wr_data;
                    end
                    default: begin
                        d.cause = q.cause;
                    end
                endcase
            end
        end

        // hardware events win over a same-cycle clear
        if (fault_event) begin
            d.irq_status[IRQ_FAULT_BIT] = 1'b1;
        end
        if (shutdown_event) begin
            d.irq_status[IRQ_SHUT_BIT] = 1'b1;
        end
        if (hot_event) begin
            d.irq_status[IRQ_HOT_BIT] = 1'b1;
        end
        d.cause = d.cause | cause_set;

        if (otp_load) begin
            d.ctl = otp_image;
        end
        if (target_addr_write) begin
            d.target = target_addr_value;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    assign sda_out          = q.sda_out;
    assign sda_oe           = q.sda_oe;
    assign ctl_image        = q.ctl;
    assign interrupt_status = q.irq_status;
    assign interrupt_masks  = q.irq_masks;
    assign shutdown_cause   = q.cause;
    assign target_addr      = q.target;

endmodule : pmrm_top

// ==== tb/pmrm_monitor.sv ====
// pmrm_monitor: port checks on the main register page.
// assumes bind onto pmrm_top; one clock, synchronous active-high reset.
module pmrm_monitor import pmrm_pkg::*; (
    input wire logic                           core_clk,
    input wire logic                           rst,
    input wire logic                           scl_in,
    input wire logic                           sda_oe,
    input wire logic                           prog_mode,
    input wire logic [6:0]                     target_addr_value,
    input wire logic                           target_addr_write,
    input wire logic                           otp_load,
    input wire logic [pmrm_pkg::NCTL-1:0][7:0] otp_image,
    input wire logic                           fault_event,
    input wire logic                           hot_event,
    input wire logic [pmrm_pkg::NCTL-1:0][7:0] ctl_image,
    input wire logic [7:0]                     interrupt_status,
    input wire logic [7:0]                     interrupt_masks,
    input wire logic [7:0]                     shutdown_cause,
    input wire logic [6:0]                     target_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence otp_pulse;
        otp_load;
    endsequence
    sequence shut_pinned;
        interrupt_status[IRQ_SHUT_BIT] && (shutdown_cause != CAUSE_RST);
    endsequence
    a_addr_reset: assert property ($past(rst) |->
        target_addr == TARGET_ADDR_RST) else $error("bad address at reset");
    a_addr_load: assert property (target_addr_write |=>
        target_addr == $past(target_addr_value)) else $error("address lost");
    a_addr_hold: assert property (!target_addr_write |=>
        $stable(target_addr)) else $error("address drifted");
    a_otp_copy: assert property (otp_pulse |=>
        ctl_image == $past(otp_image)) else $error("otp not copied");
    a_id_locked: assert property (!prog_mode && !otp_load |=>
        $stable(ctl_image[ID_LAST_IDX:0])) else $error("identity written");
    a_fault_set: assert property (fault_event |=>
        interrupt_status[IRQ_FAULT_BIT]) else $error("fault flag not set");
    a_hot_set: assert property (hot_event |=>
        interrupt_status[IRQ_HOT_BIT]) else $error("hot flag not set");
    a_fault_cause: assert property ($rose(interrupt_status[IRQ_FAULT_BIT])
        |-> $past(fault_event)) else $error("fault flag without event");
    a_shut_pinned: assert property (shut_pinned |=>
        interrupt_status[IRQ_SHUT_BIT]) else $error("shutdown flag cleared");
    a_irq_reserved: assert property ((interrupt_status & ~IRQ_BITS) == 8'h00
        && (interrupt_masks | IRQ_BITS) == 8'hFF) else $error("reserved bit");
    a_ack_timing: assert property ($rose(sda_oe) |->
        !scl_in && $past(!scl_in)) else $error("sda driven with scl high");
endmodule : pmrm_monitor

bind pmrm_top pmrm_monitor pmrm_monitor_i (
    .core_clk, .rst, .scl_in, .sda_oe, .prog_mode, .target_addr_value,
    .target_addr_write, .otp_load, .otp_image, .fault_event, .hot_event,
    .ctl_image, .interrupt_status, .interrupt_masks, .shutdown_cause,
    .target_addr
);

// ==== tb/pmrm_host.sv ====
// pmrm_host: serial-bus host model for the register page.
// assumes open-drain sda with pull-up; lines change at falling core_clk.
module pmrm_host (
    input wire logic core_clk,
    input wire logic sda_oe,
    output logic     scl_in,
    output logic     sda_in
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF = 5;
    logic scl_q = 1'h1;
    logic low_q = 1'h0;
    assign scl_in = scl_q;
    // wired-and of both pull-downs over the pull-up
    assign sda_in = ~(low_q | (sda_oe === 1'h1));
    task automatic half();
        repeat (HALF) @(negedge core_clk);
    endtask : half
    // data changes one cycle after scl low, sampled at end of scl high
    task automatic bit_io(input logic b, output logic r);
        @(negedge core_clk);
        low_q = ~b;
        half();
        scl_q = 1'h1;
        half();
        r = sda_in;
        scl_q = 1'h0;
    endtask : bit_io
    task automatic start();
        @(negedge core_clk);
        low_q = 1'h0;
        half();
        scl_q = 1'h1;
        half();
        low_q = 1'h1;
        half();
        scl_q = 1'h0;
    endtask : start
    task automatic stop();
        @(negedge core_clk);
        low_q = 1'h1;
        half();
        scl_q = 1'h1;
        half();
        low_q = 1'h0;
        half();
    endtask : stop
    // byte msb first then ack bit; all ones releases sda for reads
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ack_in, ack);
    endtask : xfer
endmodule : pmrm_host

// ==== tb/pmrm_main_register_map_bench.sv ====
// pmrm_main_register_map_bench: self-checking bench for the main page.
// assumes pmrm_host drives the pins; side inputs change at negedge.
module pmrm_main_register_map_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import pmrm_pkg::*;
    logic                 core_clk = 1'h0;
    logic                 rst = 1'h1;
    logic                 prog_mode = 1'h0;
    logic                 target_addr_write = 1'h0;
    logic                 otp_load = 1'h0;
    logic                 fault_event = 1'h0;
    logic                 shutdown_event = 1'h0;
    logic                 hot_event = 1'h0;
    logic                 die_hot = 1'h1;
    logic [6:0]           target_addr_value = 7'h5E;
    logic [6:0]           dev = 7'h5E;
    logic [7:0]           cause_set = 8'h00;
    logic [7:0]           temp_crit_status = 8'hC5;
    logic [7:0]           temp_hot_status = 8'hC6;
    logic [15:0]          good_status = 16'h5B5A;
    logic [15:0]          fault_status = 16'hC4C3;
    logic [NCTL-1:0][7:0] otp_image = '0;
    logic [NCTL-1:0][7:0] ctl_image;
    logic                 scl_in, sda_in, sda_out, sda_oe;
    logic [7:0]           interrupt_status, interrupt_masks, shutdown_cause;
    logic [6:0]           target_addr;
    logic [7:0]           offs [13] = '{8'h24, 8'h40, 8'h41, 8'h42, 8'h43,
        8'h9C, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hAC, 8'hAD, 8'hAE};
    int                   errors = 0;
    int                   compares = 0;

    always #10 core_clk = ~core_clk;

    pmrm_top pmrm_top_i (.core_clk, .rst, .scl_in, .sda_in, .sda_out,
        .sda_oe, .prog_mode, .target_addr_value, .target_addr_write,
        .otp_load, .otp_image, .fault_event, .shutdown_event, .hot_event,
        .cause_set, .die_hot, .good_status, .fault_status, .temp_crit_status,
        .temp_hot_status, .ctl_image, .interrupt_status, .interrupt_masks,
        .shutdown_cause, .target_addr);
    pmrm_host pmrm_host_i (.core_clk, .sda_oe, .scl_in, .sda_in);

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task automatic send(input logic [7:0] b, input logic e);
        logic [7:0] r;
        logic       k;
        pmrm_host_i.xfer(b, 1'h1, r, k);
        check({7'h00, k}, {7'h00, e});
    endtask : send
    task automatic wr(input logic [7:0] off, input logic [7:0] d, input int n);
        pmrm_host_i.start();
        send({dev, 1'h0}, 1'h0);
        send(off, 1'h0);
        for (int i = 0; i < n; i++) send(d + 8'(i), 1'h0);
        pmrm_host_i.stop();
    endtask : wr
    // pointer write, repeated start, then n bytes; last one not acked
    task automatic rd(input logic [7:0] off, input logic [7:0] e, input int n);
        logic [7:0] r;
        logic       k;
        pmrm_host_i.start();
        send({dev, 1'h0}, 1'h0);
        send(off, 1'h0);
        pmrm_host_i.start();
        send({dev, 1'h1}, 1'h0);
        for (int i = 0; i < n; i++) begin
            pmrm_host_i.xfer(8'hFF, i == n - 1, r, k);
            check(r, e + 8'(i));
            check({7'h00, sda_out}, 8'h00);
        end
        pmrm_host_i.stop();
    endtask : rd
    task automatic probe(input logic [6:0] a, input logic e);
        pmrm_host_i.start();
        send({a, 1'h0}, e);
        pmrm_host_i.stop();
    endtask : probe
    task automatic retarget(input logic [6:0] a);
        target_addr_value = a;
        target_addr_write = 1'h1;
        tick(1);
        target_addr_write = 1'h0;
        tick(1);
        dev = a;
    endtask : retarget

    initial begin
        tick(90000);
        errors++;
        close_out();
    end

    initial begin
        tick(4);
        rst = 1'h0;
        tick(3);
        check({1'h0, target_addr}, 8'h5E);
        check(interrupt_masks, 8'hFF);
        check(interrupt_status | shutdown_cause, 8'h00);
        rd(OFF_IRQ_MASKS, 8'hFF, 1);
        $display("test reset done");
        for (int i = 0; i < NCTL; i++) otp_image[i] = 8'(i) + 8'h10;
        otp_load = 1'h1;
        tick(1);
        otp_load = 1'h0;
        tick(1);
        check(ctl_image[27], 8'h2B);
        rd(OFF_SD_DIS_MODE, 8'h2B, 2);
        wr(OFF_ID_LOW, 8'hC3, 2);
        rd(OFF_ID_LOW, 8'h10, 2);
        prog_mode = 1'h1;
        wr(OFF_ID_LOW, 8'hC3, 2);
        rd(OFF_ID_LOW, 8'hC3, 2);
        prog_mode = 1'h0;
        $display("test otp and identity done");
        foreach (offs[i]) begin
            wr(offs[i], offs[i] ^ 8'h5A, 1);
            rd(offs[i], offs[i] ^ 8'h5A, 1);
        end
        check(ctl_image[30], 8'hFA);
        wr(OFF_FMASK_A, 8'h71, 2);
        rd(OFF_FMASK_A, 8'h71, 2);
        rd(OFF_GOOD_A, 8'h5A, 2);
        rd(OFF_FAULT_A, 8'hC3, 4);
        rd(OFF_TEMP_IND, 8'h01, 1);
        wr(8'h10, 8'hEE, 1);
        rd(8'h10, 8'h00, 1);
        $display("test control and status done");
        probe(7'h5F, 1'h1);
        probe(7'h00, 1'h1);
        probe(7'h78, 1'h1);
        retarget(7'h33);
        check({1'h0, target_addr}, 8'h33);
        probe(7'h5E, 1'h1);
        rd(OFF_RAIL_EN_A, 8'hFA, 1);
        retarget(7'h5E);
        $display("test addressing done");
        fault_event = 1'h1;
        hot_event = 1'h1;
        shutdown_event = 1'h1;
        cause_set = 8'h04;
        tick(1);
        fault_event = 1'h0;
        hot_event = 1'h0;
        shutdown_event = 1'h0;
        cause_set = 8'h00;
        tick(1);
        check(interrupt_status, 8'h89);
        check(shutdown_cause, 8'h04);
        wr(OFF_IRQ_STATUS, 8'h00, 1);
        rd(OFF_IRQ_STATUS, 8'h89, 1);
        wr(OFF_IRQ_STATUS, 8'h89, 1);
        rd(OFF_IRQ_STATUS, 8'h08, 1);
        wr(OFF_SHUT_CAUSE, 8'h04, 1);
        rd(OFF_SHUT_CAUSE, 8'h00, 1);
        wr(OFF_IRQ_STATUS, 8'h08, 1);
        rd(OFF_IRQ_STATUS, 8'h00, 1);
        wr(OFF_IRQ_MASKS, 8'h00, 1);
        rd(OFF_IRQ_MASKS, 8'h76, 1);
        $display("test interrupts done");
        close_out();
    end
endmodule : pmrm_main_register_map_bench
